// ---- hdl/switch_global_control_pkg.sv ----
// constants for the switch global control register bank
// assumes a 20 MHz core clock and an 8-bit register access port
package switch_global_control_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] GC0_ADDR = 8'h02;
  localparam logic [7:0] GC1_ADDR = 8'h03;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned GC0_BUF_SHARE_BIT = 2;
  localparam int unsigned GC0_CONF_DROP_BIT = 1;
  localparam int unsigned GC0_LINK_AGE_BIT = 0;
  localparam int unsigned GC1_PASS_ALL_BIT = 7;
  localparam int unsigned GC1_TX_PAUSE_DIS_BIT = 5;
  localparam int unsigned GC1_RX_PAUSE_DIS_BIT = 4;
  localparam int unsigned GC1_LEN_CHECK_BIT = 3;
  localparam int unsigned GC1_AGING_EN_BIT = 2;
  localparam int unsigned GC1_FAST_AGE_BIT = 1;
  localparam int unsigned GC1_BACKOFF_BIT = 0;

  // ----------------------------------------
  // reset values and masks
  // ----------------------------------------
  // strapped bits reset to their pull defaults, then take the pins
  localparam logic [7:0] GC0_RESET = 8'h04;
  localparam logic [7:0] GC0_IMPL_MASK = 8'h07;
  localparam logic [7:0] GC1_RESET = 8'h04;

  // ----------------------------------------
  // frame classification constants
  // ----------------------------------------
  localparam logic [15:0] PAUSE_ETHERTYPE = 16'h8808;
  localparam logic [47:0] PAUSE_GROUP_DA = 48'h0180C2000001;
  localparam logic [15:0] LEN_FIELD_LIMIT = 16'h05DC;

  // ----------------------------------------
  // buffer pool
  // ----------------------------------------
  localparam int unsigned POOL_BUFFERS_DEFAULT = 512;
  localparam int unsigned SHARE_DIVISOR = 5;

  // ----------------------------------------
  // aging timing
  // ----------------------------------------
  localparam longint unsigned CLK_HZ = 64'd20_000_000;
  localparam longint unsigned AGE_NORMAL_S = 64'd300;
  localparam longint unsigned AGE_FAST_US = 64'd800;
  localparam longint unsigned AGE_NORMAL_CYCLES = AGE_NORMAL_S * CLK_HZ;
  // longest time, so round down
  localparam longint unsigned AGE_FAST_CYCLES = (AGE_FAST_US * CLK_HZ) / 64'd1_000_000;
  localparam int unsigned AGE_CNT_W = 33;

  typedef enum {AGE_OFF, AGE_NORMAL, AGE_LINK_FAST} age_mode_e;

endpackage : switch_global_control_pkg

// ---- hdl/aging_timer.sv ----
// aging period generator for the address table
// assumes enables come from registers in the same clock domain
`timescale 1ns/1ps
`default_nettype none

module aging_timer #(
  parameter longint unsigned NORMAL_CYCLES = switch_global_control_pkg::AGE_NORMAL_CYCLES,
  parameter longint unsigned FAST_CYCLES = switch_global_control_pkg::AGE_FAST_CYCLES,
  parameter int unsigned CNT_W = switch_global_control_pkg::AGE_CNT_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // controls
  input wire logic aging_en_i,
  input wire logic fast_age_i,
  input wire logic link_fast_req_i,
  // status
  output logic age_tick_o,
  output logic link_fast_busy_o
);

  if (NORMAL_CYCLES < 2 || FAST_CYCLES < 2 || FAST_CYCLES > NORMAL_CYCLES ||
      NORMAL_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_period
    $error("aging_timer: periods do not fit the counter");
  end

  localparam logic [CNT_W-1:0] NORMAL_LAST = CNT_W'(NORMAL_CYCLES - 64'd1);
  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_CYCLES - 64'd1);

  switch_global_control_pkg::age_mode_e mode_reg, mode_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic tick_next;

  wire use_fast = fast_age_i || (mode_reg == switch_global_control_pkg::AGE_LINK_FAST);
  wire [CNT_W-1:0] last_cnt = use_fast ? FAST_LAST : NORMAL_LAST;
  wire expired = (cnt_reg >= last_cnt);

  always_comb begin
    mode_next = mode_reg;
    cnt_next = cnt_reg + 1'b1;
    tick_next = 1'b0;
    case (mode_reg)
      switch_global_control_pkg::AGE_OFF: begin
        cnt_next = '0;
        if (aging_en_i) begin
          mode_next = switch_global_control_pkg::AGE_NORMAL;
        end
      end
      switch_global_control_pkg::AGE_NORMAL, switch_global_control_pkg::AGE_LINK_FAST: begin
        if (expired) begin
          cnt_next = '0;
          tick_next = 1'b1;
          mode_next = switch_global_control_pkg::AGE_NORMAL;
        end
      end
      default: begin
        mode_next = switch_global_control_pkg::AGE_OFF;
        cnt_next = '0;
      end
    endcase
    // link drop restarts the count on the short period
    if (link_fast_req_i) begin
      mode_next = switch_global_control_pkg::AGE_LINK_FAST;
      cnt_next = '0;
      tick_next = 1'b0;
    end
    if (!aging_en_i) begin
      mode_next = switch_global_control_pkg::AGE_OFF;
      cnt_next = '0;
      tick_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_reg <= switch_global_control_pkg::AGE_OFF;
      cnt_reg <= '0;
      age_tick_o <= 1'b0;
      link_fast_busy_o <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
      age_tick_o <= tick_next;
      link_fast_busy_o <= (mode_next == switch_global_control_pkg::AGE_LINK_FAST);
    end
  end

endmodule : aging_timer

`default_nettype wire

// ---- hdl/switch_global_control.sv ----
// global control registers of a five-port switch and the steering they drive
// assumes register port, frame classifier and link inputs are synchronous to clk_i
//
// Overview of operation
// - buffer share set lets every port use the whole pool, clear caps each port at one fifth; resets to one.
// - with conformance drop mode set, frames with type 0x8808 or the pause group address are discarded.
// - with conformance drop mode clear (reset value), the only control frames discarded are those classified as pause frames.
// - with link-change aging on, a link drop runs one fast aging cycle, then the normal period resumes.
// - with link-change aging on, a port losing its link ages out every learned address entry.
// - pass-all (bit 7 of the second register, reset zero) forwards every frame, errored ones included.
// - transmit pause disable clear follows autonegotiation, set keeps transmit flow control off.
// - receive pause disable clear follows autonegotiation, set keeps receive flow control off.
// - both pause disable bits load from one pulled-down strap and are written independently afterwards.
// - length check set discards frames whose type/length below 1500 mismatches the real length.
// - apart from link-change flushes, addresses age only while aging enable is set; it resets from the pulled-up aging strap.
// - fast age enable switches aging to the 800 us period; resets to zero.
// - aggressive backoff selects a non-standard half-duplex backoff; resets from a pulled-down strap.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module switch_global_control #(
  parameter int unsigned NUM_PORTS = 5,
  parameter int unsigned POOL_BUFFERS = switch_global_control_pkg::POOL_BUFFERS_DEFAULT,
  parameter longint unsigned AGE_NORMAL_CYCLES = switch_global_control_pkg::AGE_NORMAL_CYCLES,
  parameter longint unsigned AGE_FAST_CYCLES = switch_global_control_pkg::AGE_FAST_CYCLES,
  localparam int unsigned BUF_W = $clog2(POOL_BUFFERS + 1)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // strap pins
  input wire logic pause_strap_pin_i,
  input wire logic aging_strap_pin_i,
  input wire logic backoff_strap_pin_i,
  // received frame classification
  input wire logic frame_valid_i,
  input wire logic [15:0] frame_type_len_i,
  input wire logic [47:0] frame_da_i,
  input wire logic frame_is_pause_i,
  input wire logic frame_error_i,
  input wire logic [15:0] frame_actual_len_i,
  output logic frame_done_o,
  output logic frame_drop_o,
  // buffer pool
  output logic buffer_share_o,
  output logic [BUF_W-1:0] port_buffer_limit_o,
  // flow control
  input wire logic [NUM_PORTS-1:0] an_tx_pause_i,
  input wire logic [NUM_PORTS-1:0] an_rx_pause_i,
  output logic [NUM_PORTS-1:0] tx_flow_en_o,
  output logic [NUM_PORTS-1:0] rx_flow_en_o,
  // address aging
  input wire logic [NUM_PORTS-1:0] link_up_i,
  output logic age_tick_o,
  output logic fast_aging_o,
  output logic flush_all_o,
  // mac behaviour
  output logic pass_all_o,
  output logic aggressive_backoff_o
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // the per-port share must still be at least one buffer
  if (NUM_PORTS < 1 || POOL_BUFFERS < switch_global_control_pkg::SHARE_DIVISOR) begin : g_bad_params
    $error("switch_global_control: port count or pool size unusable");
  end

  localparam logic [BUF_W-1:0] FULL_LIMIT = BUF_W'(POOL_BUFFERS);
  localparam logic [BUF_W-1:0] SHARE_LIMIT = BUF_W'(POOL_BUFFERS / switch_global_control_pkg::SHARE_DIVISOR);

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic [7:0] gc0_reg, gc0_next;
  logic [7:0] gc1_reg, gc1_next;
  logic strap_done_reg;
  logic [NUM_PORTS-1:0] link_prev_reg;

  // one compare shared by the write and read decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction : addr_hit

  wire rd_gc0 = addr_hit(reg_addr_i, switch_global_control_pkg::GC0_ADDR);
  wire rd_gc1 = addr_hit(reg_addr_i, switch_global_control_pkg::GC1_ADDR);
  wire wr_gc0 = reg_wr_i && rd_gc0;
  wire wr_gc1 = reg_wr_i && rd_gc1;
  // unmapped addresses read zero
  wire [7:0] read_mux = rd_gc0 ? gc0_reg : (rd_gc1 ? gc1_reg : 8'h00);

  wire buf_share = gc0_reg[switch_global_control_pkg::GC0_BUF_SHARE_BIT];
  wire conf_drop = gc0_reg[switch_global_control_pkg::GC0_CONF_DROP_BIT];
  wire link_age = gc0_reg[switch_global_control_pkg::GC0_LINK_AGE_BIT];
  wire pass_all = gc1_reg[switch_global_control_pkg::GC1_PASS_ALL_BIT];
  wire tx_pause_dis = gc1_reg[switch_global_control_pkg::GC1_TX_PAUSE_DIS_BIT];
  wire rx_pause_dis = gc1_reg[switch_global_control_pkg::GC1_RX_PAUSE_DIS_BIT];
  wire len_check = gc1_reg[switch_global_control_pkg::GC1_LEN_CHECK_BIT];
  wire aging_en = gc1_reg[switch_global_control_pkg::GC1_AGING_EN_BIT];
  wire fast_age = gc1_reg[switch_global_control_pkg::GC1_FAST_AGE_BIT];
  wire backoff = gc1_reg[switch_global_control_pkg::GC1_BACKOFF_BIT];

  // ----------------------------------------
  // strap capture
  // ----------------------------------------
  // flops under async reset may only take constants, so the pins are
  // taken on the first edge after release instead of during reset
  logic [7:0] gc1_strapped;
  always_comb begin
    gc1_strapped = gc1_reg;
    gc1_strapped[switch_global_control_pkg::GC1_TX_PAUSE_DIS_BIT] = pause_strap_pin_i;
    gc1_strapped[switch_global_control_pkg::GC1_RX_PAUSE_DIS_BIT] = pause_strap_pin_i;
    gc1_strapped[switch_global_control_pkg::GC1_AGING_EN_BIT] = aging_strap_pin_i;
    gc1_strapped[switch_global_control_pkg::GC1_BACKOFF_BIT] = backoff_strap_pin_i;
  end

  // upper bits of the first register are not held here and read zero
  assign gc0_next = wr_gc0 ? (reg_wdata_i & switch_global_control_pkg::GC0_IMPL_MASK) : gc0_reg;
  // strap load once, then software owns every bit, each one separately
  assign gc1_next = !strap_done_reg ? gc1_strapped : (wr_gc1 ? reg_wdata_i : gc1_reg);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gc0_reg <= switch_global_control_pkg::GC0_RESET;
      gc1_reg <= switch_global_control_pkg::GC1_RESET;
      strap_done_reg <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      gc0_reg <= gc0_next;
      gc1_reg <= gc1_next;
      strap_done_reg <= 1'b1;
      reg_rdata_o <= reg_rd_i ? read_mux : 8'h00;
    end
  end

  // ----------------------------------------
  // frame drop decision
  // ----------------------------------------
  // classifier fields only matter while frame_valid_i is high
  wire conf_match = (frame_type_len_i == switch_global_control_pkg::PAUSE_ETHERTYPE) ||
                    (frame_da_i == switch_global_control_pkg::PAUSE_GROUP_DA);
  wire ctrl_drop = conf_drop ? conf_match : frame_is_pause_i;
  wire len_bad = len_check && (frame_type_len_i < switch_global_control_pkg::LEN_FIELD_LIMIT) &&
                 (frame_type_len_i != frame_actual_len_i);
  // pass-all is a debug escape hatch and overrides every discard reason
  wire drop_next = frame_valid_i && !pass_all && (ctrl_drop || len_bad || frame_error_i);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_done_o <= 1'b0;
      frame_drop_o <= 1'b0;
    end else begin
      frame_done_o <= frame_valid_i;
      frame_drop_o <= drop_next;
    end
  end

  // ----------------------------------------
  // steering outputs
  // ----------------------------------------
  // registered copies, so downstream logic never sees decode glitches
  wire [BUF_W-1:0] limit_next = buf_share ? FULL_LIMIT : SHARE_LIMIT;
  wire [NUM_PORTS-1:0] tx_en_next = an_tx_pause_i & {NUM_PORTS{!tx_pause_dis}};
  wire [NUM_PORTS-1:0] rx_en_next = an_rx_pause_i & {NUM_PORTS{!rx_pause_dis}};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      buffer_share_o <= 1'b1;
      port_buffer_limit_o <= FULL_LIMIT;
      tx_flow_en_o <= '0;
      rx_flow_en_o <= '0;
      pass_all_o <= 1'b0;
      aggressive_backoff_o <= 1'b0;
    end else begin
      buffer_share_o <= buf_share;
      port_buffer_limit_o <= limit_next;
      tx_flow_en_o <= tx_en_next;
      rx_flow_en_o <= rx_en_next;
      pass_all_o <= pass_all;
      aggressive_backoff_o <= backoff;
    end
  end

  // ----------------------------------------
  // link change aging
  // ----------------------------------------
  // reset to all-down so a link already up at release is not a drop
  // a drop on any port counts, whatever caused the link loss
  wire link_drop = |(link_prev_reg & ~link_up_i);
  wire link_event = link_age && link_drop;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_prev_reg <= '0;
      flush_all_o <= 1'b0;
    end else begin
      link_prev_reg <= link_up_i;
      flush_all_o <= link_event;
    end
  end

  aging_timer #(
    .NORMAL_CYCLES(AGE_NORMAL_CYCLES),
    .FAST_CYCLES(AGE_FAST_CYCLES),
    .CNT_W(switch_global_control_pkg::AGE_CNT_W)
  ) u_aging_timer (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .aging_en_i(aging_en),
    .fast_age_i(fast_age),
    .link_fast_req_i(link_event),
    .age_tick_o(age_tick_o),
    .link_fast_busy_o(fast_aging_o)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_buffer_limit: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    port_buffer_limit_o == (buffer_share_o ? FULL_LIMIT : SHARE_LIMIT))
    else $error("buffer limit does not follow share mode");

  a_conf_drop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    frame_valid_i && conf_drop && !pass_all && conf_match |=> frame_done_o && frame_drop_o)
    else $error("conformance frame not dropped");

  a_pause_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    frame_valid_i && !conf_drop && !pass_all && !frame_is_pause_i && !frame_error_i && !len_bad
    |=> frame_done_o && !frame_drop_o)
    else $error("non-pause frame dropped in normal mode");

  a_link_fast: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    link_event && aging_en ##1 aging_en |=> fast_aging_o && !age_tick_o)
    else $error("link drop did not start fast aging");

  a_flush_link: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    strap_done_reg && link_age && |($past(link_up_i) & ~link_up_i) |=> flush_all_o)
    else $error("link loss did not flush address table");

  a_pass_all: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    frame_valid_i && pass_all |=> frame_done_o && !frame_drop_o)
    else $error("frame dropped in pass-all mode");

  a_tx_pause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    tx_pause_dis |=> tx_flow_en_o == '0)
    else $error("tx flow control on while disabled");

  a_rx_pause: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !rx_pause_dis |=> rx_flow_en_o == $past(an_rx_pause_i))
    else $error("rx flow control does not follow negotiation");

  a_strap_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(strap_done_reg) |-> tx_pause_dis == $past(pause_strap_pin_i) &&
    rx_pause_dis == $past(pause_strap_pin_i) && aging_en == $past(aging_strap_pin_i))
    else $error("strap value not loaded at reset release");

  a_len_check: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    frame_valid_i && len_check && !pass_all &&
    frame_type_len_i < switch_global_control_pkg::LEN_FIELD_LIMIT &&
    frame_type_len_i != frame_actual_len_i |=> frame_drop_o)
    else $error("length mismatch frame not dropped");

  a_aging_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !aging_en [*2] |=> !age_tick_o && !fast_aging_o)
    else $error("aging active while disabled");

  a_sw_override: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    strap_done_reg && wr_gc1 |=> gc1_reg == $past(reg_wdata_i) && strap_done_reg)
    else $error("software write lost against strap");

  a_backoff_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    strap_done_reg ##1 1'b1 |-> aggressive_backoff_o == $past(backoff))
    else $error("backoff output does not follow register");

  // second edge after release: straps loaded, other bits still at reset
  a_reset_bits: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(strap_done_reg) |-> buf_share && !conf_drop && !link_age && !pass_all && !fast_age)
    else $error("register bits off their reset values");

  a_strap_backoff: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(strap_done_reg) |-> backoff == $past(backoff_strap_pin_i))
    else $error("backoff strap not loaded at reset release");

  a_gc0_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    wr_gc0 |=> gc0_reg == ($past(reg_wdata_i) & switch_global_control_pkg::GC0_IMPL_MASK))
    else $error("first register write lost");

  a_share_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> buffer_share_o == $past(buf_share))
    else $error("share output does not follow register");

  a_pause_drop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    frame_valid_i && !conf_drop && !pass_all && frame_is_pause_i |=> frame_drop_o)
    else $error("pause frame not dropped");

  a_error_drop: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    frame_valid_i && frame_error_i && !pass_all |=> frame_drop_o)
    else $error("errored frame kept without pass-all");

  a_drop_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !frame_valid_i |=> !frame_done_o && !frame_drop_o)
    else $error("frame result outside its cycle");

  a_pass_out: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    1'b1 |=> pass_all_o == $past(pass_all))
    else $error("pass-all output does not follow register");

  a_tx_follow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !tx_pause_dis |=> tx_flow_en_o == $past(an_tx_pause_i))
    else $error("tx flow control does not follow negotiation");

  a_rx_off: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    rx_pause_dis |=> rx_flow_en_o == '0)
    else $error("rx flow control on while disabled");

  a_no_flush: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !link_age |=> !flush_all_o)
    else $error("flush without link-change aging");

  // periods of at least two cycles keep the tick a single pulse
  a_tick_pulse: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    age_tick_o |=> !age_tick_o)
    else $error("aging tick longer than one cycle");

  a_fast_ends: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    age_tick_o |-> !fast_aging_o)
    else $error("fast aging still flagged after its cycle");

  a_fast_gated: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !aging_en |=> !fast_aging_o && !age_tick_o)
    else $error("aging activity while disabled");

endmodule : switch_global_control

`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the switch global control register bank
// assumes shortened aging counts and the default pool size
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// compare macro
// ----------------------------------------
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end

module tb_top;
  localparam longint unsigned NCYC = 40;
  localparam longint unsigned FCYC = 8;
  localparam int unsigned NP = 5;
  logic clk, arst_n, wr, rd, fv, fpause, ferr;
  logic [7:0] addr, wdata, exp2, exp3;
  logic [15:0] ftl, flen;
  logic [47:0] fda;
  logic p_strap, a_strap, b_strap;
  logic [NP-1:0] an_tx, an_rx, link;
  logic [7:0] rdata;
  logic fdone, fdrop, share, tick, fast, flush, pass, boff;
  logic [9:0] limit;
  logic [NP-1:0] txf, rxf;
  int n_fail = 0;
  int tests_run = 0;
  int n;
  bit exp_q[$];

  switch_global_control #(.AGE_NORMAL_CYCLES(NCYC), .AGE_FAST_CYCLES(FCYC)) dut (
    .clk_i(clk), .arst_n_i(arst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .pause_strap_pin_i(p_strap), .aging_strap_pin_i(a_strap),
    .backoff_strap_pin_i(b_strap), .frame_valid_i(fv), .frame_type_len_i(ftl), .frame_da_i(fda),
    .frame_is_pause_i(fpause), .frame_error_i(ferr), .frame_actual_len_i(flen),
    .frame_done_o(fdone), .frame_drop_o(fdrop), .buffer_share_o(share), .port_buffer_limit_o(limit),
    .an_tx_pause_i(an_tx), .an_rx_pause_i(an_rx), .tx_flow_en_o(txf), .rx_flow_en_o(rxf),
    .link_up_i(link), .age_tick_o(tick), .fast_aging_o(fast), .flush_all_o(flush),
    .pass_all_o(pass), .aggressive_backoff_o(boff));

  // ----------------------------------------
  // clock, tasks
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic do_reset(input logic ps, input logic as, input logic bs);
    @(posedge clk) begin
      arst_n <= 1'b0;
      p_strap <= ps;
      a_strap <= as;
      b_strap <= bs;
    end
    repeat (7) @(posedge clk);
    #1;
    `CHK("share in reset", 1'b1, share)
    `CHK("limit in reset", 10'd512, limit)
    @(posedge clk) arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    exp2 = 8'h04;
    exp3 = {2'b00, ps, ps, 1'b0, as, 1'b0, bs};
  endtask : do_reset

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
    end
    @(posedge clk) wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) begin
      rd <= 1'b1;
      addr <= a;
    end
    @(posedge clk) rd <= 1'b0;
    #1;
    `CHK("read data", e, rdata)
    @(posedge clk);
    #1;
    `CHK("read data idle", 8'h00, rdata)
  endtask : reg_rd

  // outputs settle two edges after the last write
  task automatic chk_outs();
    repeat (2) @(posedge clk);
    #1;
    `CHK("share", exp2[2], share)
    `CHK("limit", exp2[2] ? 10'd512 : 10'd102, limit)
    `CHK("pass all", exp3[7], pass)
    `CHK("tx flow", an_tx & {NP{~exp3[5]}}, txf)
    `CHK("rx flow", an_rx & {NP{~exp3[4]}}, rxf)
    `CHK("backoff", exp3[0], boff)
  endtask : chk_outs

  // counts cycles up to the next tick, n = -1 if none within lim
  task automatic wait_tick(input int lim);
    n = -1;
    for (int i = 1; i <= lim && n < 0; i++) begin
      @(posedge clk);
      #1;
      if (tick === 1'b1) n = i;
    end
  endtask : wait_tick

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic e;
    logic [7:0] wd;
    logic [15:0] tl;
    arst_n = 1'b0;
    {wr, rd, fv, fpause, ferr} = '0;
    {addr, wdata, ftl, flen, fda} = '0;
    an_tx = '0;
    an_rx = '0;
    link = '1;
    void'($urandom(32'hbf20ad7a));
    do_reset(1'b1, 1'b0, 1'b1);
    reg_rd(8'h02, exp2);
    reg_rd(8'h03, exp3);
    chk_outs();
    $display("test strap reset done");
    for (int i = 0; i < 10; i++) begin
      wd = 8'($urandom);
      reg_wr(8'h02, wd);
      exp2 = wd & 8'h07;
      exp3 = 8'($urandom);
      reg_wr(8'h03, exp3);
      reg_wr(8'h05 + 8'($urandom % 8), 8'($urandom));
      an_tx <= NP'($urandom);
      an_rx <= NP'($urandom);
      reg_rd(8'h02, exp2);
      reg_rd(8'h03, exp3);
      reg_rd(8'h0C, 8'h00);
      chk_outs();
    end
    $display("test register access done");
    for (int i = 0; i < 96; i++) begin
      if (i % 8 == 0) begin
        reg_wr(8'h02, {5'h00, 1'b1, i[3], 1'b0});
        reg_wr(8'h03, {i[6], 3'b000, i[4], 3'b100});
        exp2 = {5'h00, 1'b1, i[3], 1'b0};
        exp3 = {i[6], 3'b000, i[4], 3'b100};
      end
      @(posedge clk) begin
        tl = ($urandom % 3 == 0) ? 16'h8808 : 16'($urandom % 1600);
        fv <= 1'b1;
        ftl <= tl;
        fda <= ($urandom % 4 == 0) ? 48'h0180C2000001 : {$urandom, 16'($urandom)};
        fpause <= ($urandom % 4 == 0);
        ferr <= ($urandom % 6 == 0);
        flen <= ($urandom % 2 == 0) ? 16'($urandom % 1600) : tl;
      end
      @(posedge clk) fv <= 1'b0;
      #1;
      exp_q.push_back(!exp3[7] && (ferr || (exp3[3] && ftl < 16'd1500 && ftl != flen) ||
          (exp2[1] ? (ftl == 16'h8808 || fda == 48'h0180C2000001) : fpause)));
      e = exp_q.pop_front();
      `CHK("frame done", 1'b1, fdone)
      `CHK("frame drop", e, fdrop)
    end
    $display("test frame decision done");
    reg_wr(8'h03, 8'h04);
    wait_tick(3 * NCYC);
    wait_tick(3 * NCYC);
    `CHK("normal period", int'(NCYC), n)
    reg_wr(8'h03, 8'h06);
    wait_tick(3 * NCYC);
    wait_tick(3 * NCYC);
    `CHK("fast period", int'(FCYC), n)
    reg_wr(8'h03, 8'h00);
    repeat (2) @(posedge clk);
    wait_tick(3 * NCYC);
    `CHK("aging off", -1, n)
    $display("test aging period done");
    reg_wr(8'h02, 8'h05);
    reg_wr(8'h03, 8'h04);
    repeat (NCYC / 2) @(posedge clk);
    link <= 5'b11011;
    n = -1;
    for (int i = 0; i < 4 && n < 0; i++) begin
      @(posedge clk);
      #1;
      if (flush === 1'b1) n = i;
    end
    `CHK("flush seen", 1'b1, n >= 0)
    `CHK("fast aging on", 1'b1, fast)
    @(posedge clk);
    #1;
    `CHK("flush one cycle", 1'b0, flush)
    wait_tick(int'(FCYC) + 2);
    // tick due FCYC edges after the drop, one edge already spent
    `CHK("fast cycle ends", int'(FCYC) - 1, n)
    @(posedge clk);
    #1;
    `CHK("fast aging off", 1'b0, fast)
    wait_tick(3 * NCYC);
    `CHK("normal resumes", int'(NCYC) - 1, n)
    @(posedge clk) link <= '1;
    reg_wr(8'h02, 8'h04);
    link <= 5'b01111;
    n = 0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (flush === 1'b1) n++;
    end
    `CHK("no flush when off", 0, n)
    $display("test link change done");
    do_reset(1'b0, 1'b1, 1'b0);
    reg_rd(8'h03, exp3);
    reg_wr(8'h03, 8'h31);
    exp3 = 8'h31;
    reg_rd(8'h03, exp3);
    chk_outs();
    $display("test strap override done");
    report_and_stop();
  end

  initial begin
    #(50 * 20000);
    n_fail++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
